// ===== logic/tbid_params.svh
// Offsets, field positions, reset values and counts of the instruction decoder
`ifndef TBID_PARAMS_SVH
`define TBID_PARAMS_SVH

// Register byte offsets on the AXI4-Lite slave
`define TBID_OFF_INSTR 4'h0
`define TBID_OFF_CTRL 4'h4
`define TBID_OFF_STATUS 4'h8
`define TBID_OFF_DECODE 4'hc

// Register resets
`define TBID_RST_WORD 12'h000
`define TBID_RST_RUN 1'h0
`define TBID_RST_TIMEOUT 1'h1
`define TBID_RST_POWERDOWN 1'h1

// Flag update masks, bit 2 carry, bit 1 digit carry, bit 0 zero
`define TBID_FLAGS_NONE 3'h0
`define TBID_FLAGS_Z 3'h1
`define TBID_FLAGS_C 3'h4
`define TBID_FLAGS_ARITH 3'h7

// File address of the program counter low byte
`define TBID_PC_FILE 5'h02

// Oscillator periods per instruction cycle, as last phase index
`define TBID_LAST_PHASE 2'h3

// Bus responses
`define TBID_RESP_OKAY 2'h0
`define TBID_RESP_SLVERR 2'h2

`endif

// ===== logic/tbid_pkg.sv
// Types shared by the instruction decoder
package tbid_pkg;

    typedef enum logic [4:0] {
        no_operation = 5'b00000,
        add_acc_to_file = 5'b00001,
        subtract_acc_from_file = 5'b00010,
        and_acc_with_file = 5'b00011,
        or_acc_with_file = 5'b00100,
        xor_acc_with_file = 5'b00101,
        invert_file = 5'b00110,
        plus_one_file = 5'b00111,
        minus_one_file = 5'b01000,
        copy_file = 5'b01001,
        zero_file = 5'b01010,
        store_acc_to_file = 5'b01011,
        rotate_left_carry = 5'b01100,
        rotate_right_carry = 5'b01101,
        nibble_exchange = 5'b01110,
        bit_zero = 5'b01111,
        bit_one = 5'b10000,
        bit_test = 5'b10001,
        and_constant = 5'b10010,
        or_constant = 5'b10011,
        xor_constant = 5'b10100,
        load_constant = 5'b10101,
        call_subroutine = 5'b10110,
        return_with_constant = 5'b10111,
        jump_absolute = 5'b11000,
        prescaler_load = 5'b11001,
        standby_enter = 5'b11010,
        watchdog_restart = 5'b11011,
        direction_latch_load = 5'b11100,
        zero_acc = 5'b11101,
        minus_one_skip_zero = 5'b11110,
        plus_one_skip_zero = 5'b11111
    } tbid_op_type;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_first = 2'b01,
        st_second = 2'b10
    } tbid_state_type;

    typedef struct packed {
        tbid_op_type op;
        logic dest_file;
        logic [2:0] flags;
        logic reads_file;
        logic skip_zero;
        logic skip_clear;
        logic skip_set;
        logic pc_change;
        logic is_jump;
        logic clear_pc9;
    } tbid_dec_type;

endpackage : tbid_pkg

// ===== logic/tbid_decoder.sv
// Twelve-bit instruction decoder and four-phase sequencer with AXI4-Lite access
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "tbid_params.svh"

module tbid_decoder
    import tbid_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Datapath feedback
    input wire logic result_zero,
    input wire logic test_bit,
    // Decoded fields
    output tbid_op_type op,
    output logic dest_file,
    output logic [4:0] file_addr,
    output logic [2:0] bit_sel,
    output logic [8:0] literal,
    output logic [2:0] flag_update,
    output logic source_pins,
    output logic pc_load,
    output logic pc_bit9_clear,
    // Sequencing
    output logic busy,
    output logic [1:0] phase,
    output logic squash,
    // Watchdog and power control
    output logic wdt_restart,
    output logic standby_pulse,
    output logic osc_off,
    output logic timeout_flag,
    output logic powerdown_flag
);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tbid_state_type state;
    tbid_dec_type dec;
    logic [11:0] wr_word;
    logic [11:0] ex_word;
    logic pending;
    logic run;
    logic wr_take;
    logic accept;
    logic last_phase;
    logic skip_hit;

    function automatic tbid_dec_type decode(input logic [11:0] w);
        tbid_dec_type d;
        d = '0;
        d.op = no_operation;
        if (w[11:10] == 2'h0) begin
            d.dest_file = w[5];
            d.reads_file = 1'b1;
            d.flags = `TBID_FLAGS_Z;
            case (w[9:6])
                4'h0: begin
                    d.reads_file = 1'b0;
                    d.flags = `TBID_FLAGS_NONE;
                    if (w[5]) begin
                        d.op = store_acc_to_file;
                    end else if (w[4:0] == 5'h02) begin
                        d.op = prescaler_load;
                    end else if (w[4:0] == 5'h03) begin
                        d.op = standby_enter;
                    end else if (w[4:0] == 5'h04) begin
                        d.op = watchdog_restart;
                    end else if (w[4:3] == 2'h0 && w[2:0] >= 3'h5) begin
                        d.op = direction_latch_load;
                    end
                end
                4'h1: begin
                    d.reads_file = 1'b0;
                    if (w[5]) begin
                        d.op = zero_file;
                    end else if (w[4:0] == 5'h00) begin
                        d.op = zero_acc;
                    end else begin
                        d.flags = `TBID_FLAGS_NONE;
                    end
                end
                4'h2: begin
                    d.op = subtract_acc_from_file;
                    d.flags = `TBID_FLAGS_ARITH;
                end
                4'h3: d.op = minus_one_file;
                4'h4: d.op = or_acc_with_file;
                4'h5: d.op = and_acc_with_file;
                4'h6: d.op = xor_acc_with_file;
                4'h7: begin
                    d.op = add_acc_to_file;
                    d.flags = `TBID_FLAGS_ARITH;
                end
                4'h8: d.op = copy_file;
                4'h9: d.op = invert_file;
                4'ha: d.op = plus_one_file;
                4'hb: begin
                    d.op = minus_one_skip_zero;
                    d.flags = `TBID_FLAGS_NONE;
                    d.skip_zero = 1'b1;
                end
                4'hc: begin
                    d.op = rotate_right_carry;
                    d.flags = `TBID_FLAGS_C;
                end
                4'hd: begin
                    d.op = rotate_left_carry;
                    d.flags = `TBID_FLAGS_C;
                end
                4'he: begin
                    d.op = nibble_exchange;
                    d.flags = `TBID_FLAGS_NONE;
                end
                default: begin
                    d.op = plus_one_skip_zero;
                    d.flags = `TBID_FLAGS_NONE;
                    d.skip_zero = 1'b1;
                end
            endcase
        end else if (w[11:10] == 2'h1) begin
            d.reads_file = 1'b1;
            case (w[9:8])
                2'h0: begin
                    d.op = bit_zero;
                    d.dest_file = 1'b1;
                end
                2'h1: begin
                    d.op = bit_one;
                    d.dest_file = 1'b1;
                end
                2'h2: begin
                    d.op = bit_test;
                    d.skip_clear = 1'b1;
                end
                default: begin
                    d.op = bit_test;
                    d.skip_set = 1'b1;
                end
            endcase
        end else begin
            casez (w[11:8])
                4'b1000: d.op = return_with_constant;
                4'b1001: d.op = call_subroutine;
                4'b101?: d.op = jump_absolute;
                4'b1100: d.op = load_constant;
                4'b1101: d.op = or_constant;
                4'b1110: d.op = and_constant;
                default: d.op = xor_constant;
            endcase
            // Only 1000, 1001 and 101x redirect the program
            if (w[11:10] == 2'h2) begin
                d.pc_change = 1'b1;
            end else if (w[11:8] != 4'hc) begin
                d.flags = `TBID_FLAGS_Z;
            end
            d.is_jump = (w[11:9] == 3'h5);
        end
        // A file write to the PC low byte also redirects the program
        if (!w[11] && d.dest_file && w[4:0] == `TBID_PC_FILE) begin
            d.pc_change = 1'b1;
        end
        d.clear_pc9 = d.pc_change && !d.is_jump;
        return d;
    endfunction : decode

    // Writes to the instruction register stall until the last word is taken
    assign wr_take = awvalid && wvalid && !bvalid && !(awaddr == `TBID_OFF_INSTR && pending);
    assign awready = wr_take;
    assign wready = wr_take;
    assign arready = !rvalid;
    assign accept = (state == st_idle) && run && pending;
    assign last_phase = (phase == `TBID_LAST_PHASE);
    assign skip_hit = (dec.skip_zero && result_zero) || (dec.skip_clear && !test_bit)
        || (dec.skip_set && test_bit);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_word <= `TBID_RST_WORD;
            run <= `TBID_RST_RUN;
            bvalid <= 1'b0;
            bresp <= `TBID_RESP_OKAY;
        end else begin
            if (wr_take) begin
                bvalid <= 1'b1;
                bresp <= `TBID_RESP_OKAY;
                if (awaddr == `TBID_OFF_INSTR) begin
                    if (wstrb[1]) begin
                        wr_word[11:8] <= wdata[11:8];
                    end
                    if (wstrb[0]) begin
                        wr_word[7:0] <= wdata[7:0];
                    end
                end else if (awaddr == `TBID_OFF_CTRL) begin
                    if (wstrb[0]) begin
                        run <= wdata[0];
                    end
                end else begin
                    bresp <= `TBID_RESP_SLVERR;
                end
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // New word wins over the take in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= 1'b0;
        end else if (wr_take && awaddr == `TBID_OFF_INSTR && wstrb[1:0] != 2'h0) begin
            pending <= 1'b1;
        end else if (accept) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `TBID_RESP_OKAY;
        end else if (arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp <= `TBID_RESP_OKAY;
            if (araddr == `TBID_OFF_INSTR) begin
                rdata <= {20'h0_0000, wr_word};
            end else if (araddr == `TBID_OFF_CTRL) begin
                rdata <= {31'h0000_0000, run};
            end else if (araddr == `TBID_OFF_STATUS) begin
                rdata <= {23'h00_0000, state, pending, phase, squash, osc_off,
                    timeout_flag, powerdown_flag};
            end else if (araddr == `TBID_OFF_DECODE) begin
                rdata <= {16'h0000, dec};
            end else begin
                rdata <= 32'h0000_0000;
                rresp <= `TBID_RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Four clock periods per instruction cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= st_idle;
            phase <= 2'h0;
        end else begin
            case (state)
                st_idle: begin
                    phase <= 2'h0;
                    if (accept) begin
                        state <= st_first;
                    end
                end
                st_first: begin
                    phase <= phase + 2'h1;
                    if (last_phase) begin
                        state <= (dec.pc_change || skip_hit) ? st_second : st_idle;
                    end
                end
                st_second: begin
                    phase <= phase + 2'h1;
                    if (last_phase) begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ex_word <= `TBID_RST_WORD;
            dec <= '0;
        end else if (accept) begin
            ex_word <= wr_word;
            dec <= decode(wr_word);
        end
    end

    // Watchdog and power effects land at the end of the first cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_restart <= 1'b0;
            standby_pulse <= 1'b0;
            osc_off <= 1'b0;
            timeout_flag <= `TBID_RST_TIMEOUT;
            powerdown_flag <= `TBID_RST_POWERDOWN;
        end else begin
            wdt_restart <= 1'b0;
            standby_pulse <= 1'b0;
            if (state == st_first && last_phase) begin
                if (dec.op == watchdog_restart) begin
                    wdt_restart <= 1'b1;
                    timeout_flag <= 1'b1;
                    powerdown_flag <= 1'b1;
                end else if (dec.op == standby_enter) begin
                    wdt_restart <= 1'b1;
                    standby_pulse <= 1'b1;
                    osc_off <= 1'b1;
                    timeout_flag <= 1'b1;
                    powerdown_flag <= 1'b0;
                end
            end
        end
    end

    assign op = dec.op;
    assign dest_file = dec.dest_file;
    assign file_addr = ex_word[4:0];
    assign bit_sel = ex_word[7:5];
    assign literal = dec.is_jump ? ex_word[8:0] : {1'b0, ex_word[7:0]};
    assign flag_update = dec.flags;
    assign source_pins = dec.reads_file && dec.dest_file;
    assign pc_load = dec.pc_change;
    assign pc_bit9_clear = dec.clear_pc9;
    assign busy = (state != st_idle);
    assign squash = (state == st_second);

    first_span_a: assert property ($rose(busy) |-> (busy && !squash)[*4])
        else $error("first cycle not four clocks");
    second_cycle_a: assert property (state == st_first && last_phase && pc_load
        |=> squash[*4] ##1 !busy)
        else $error("pc change did not take two cycles");
    single_cycle_a: assert property (state == st_first && last_phase && !pc_load
        && !skip_hit |=> !busy)
        else $error("plain instruction took more than one cycle");
    bit_skip_a: assert property (state == st_first && last_phase && op == bit_test
        && (test_bit == dec.skip_set) |=> squash)
        else $error("bit test skip not taken");
    dest_select_a: assert property (accept && wr_word[11:8] == 4'h1
        |=> dest_file == $past(wr_word[5]))
        else $error("destination bit not followed");
    bit_flags_a: assert property (busy && (op == bit_zero || op == bit_one)
        |-> flag_update == `TBID_FLAGS_NONE && dest_file)
        else $error("bit op touched flags");
    pc_bit9_a: assert property (busy && pc_load
        |-> pc_bit9_clear == (op != jump_absolute))
        else $error("pc bit 9 clear wrong");
    standby_effect_a: assert property (standby_pulse |-> wdt_restart ##1
        (timeout_flag && !powerdown_flag && osc_off))
        else $error("standby effects missing");
    add_flags_a: assert property (busy && op == add_acc_to_file
        |-> flag_update == `TBID_FLAGS_ARITH)
        else $error("add flags wrong");

    skip_taken_c: cover property (state == st_first && last_phase && skip_hit);
    jump_seen_c: cover property (busy && op == jump_absolute ##1 squash);
    standby_seen_c: cover property (standby_pulse);

endmodule : tbid_decoder

// ===== tb/tbid_datapath_model.sv
// Behavioural file-register datapath that answers the decoder's skip tests
`timescale 1ns/100ps
module tbid_datapath_model (
    // Clock
    input wire logic aclk,
    // Decoder sequencing
    input wire logic busy,
    input wire logic squash,
    // Test answers commanded by the bench
    input wire logic want_zero,
    input wire logic want_bit,
    // Feedback to the decoder
    output logic result_zero,
    output logic test_bit
);
    logic churn = 1'b0;

    // Outside a first cycle the answers mean nothing, so they keep moving
    always_ff @(posedge aclk) begin
        churn <= ~churn;
    end

    assign result_zero = (busy && !squash) ? want_zero : churn;
    assign test_bit = (busy && !squash) ? want_bit : ~churn;
endmodule : tbid_datapath_model

// ===== tb/twelve_bit_instruction_decoder_tb_top.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
module twelve_bit_instruction_decoder_tb_top;
    import tbid_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic want_zero = 1'b0, want_bit = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, result_zero, test_bit;
    logic [1:0] bresp, rresp, phase;
    logic [31:0] rdata;
    tbid_op_type op;
    logic dest_file, source_pins, pc_load, pc_bit9_clear, busy, squash;
    logic wdt_restart, standby_pulse, osc_off, timeout_flag, powerdown_flag;
    logic [4:0] file_addr;
    logic [2:0] bit_sel, flag_update;
    logic [8:0] literal;
    logic [15:0] lfsr = 16'h0041;
    logic eto = 1'b1, epd = 1'b1, eosc = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    logic [11:0] prog [0:37] = '{12'h1c0, 12'h080, 12'h140, 12'h100, 12'h180, 12'h240,
        12'h280, 12'h0c0, 12'h200, 12'h2c0, 12'h3c0, 12'h340, 12'h300, 12'h380, 12'h060,
        12'h020, 12'h040, 12'h400, 12'h500, 12'h600, 12'h700, 12'he00, 12'hd00, 12'hf00,
        12'hc00, 12'h900, 12'h800, 12'ha00, 12'h000, 12'h001, 12'h002, 12'h005, 12'h006,
        12'h007, 12'h008, 12'h041, 12'h004, 12'h003};

    always #2.5 aclk = ~aclk;

    tbid_decoder tbid_decoder_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .result_zero(result_zero), .test_bit(test_bit), .op(op),
        .dest_file(dest_file), .file_addr(file_addr), .bit_sel(bit_sel), .literal(literal),
        .flag_update(flag_update), .source_pins(source_pins), .pc_load(pc_load),
        .pc_bit9_clear(pc_bit9_clear), .busy(busy), .phase(phase), .squash(squash),
        .wdt_restart(wdt_restart), .standby_pulse(standby_pulse), .osc_off(osc_off),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

    tbid_datapath_model tbid_datapath_model_i (.aclk(aclk), .busy(busy), .squash(squash),
        .want_zero(want_zero), .want_bit(want_bit), .result_zero(result_zero),
        .test_bit(test_bit));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : check_word

    task automatic check_field(input logic [8:0] got, input logic [8:0] exp, input string m);
        check_word({23'h00_0000, got}, {23'h00_0000, exp}, m);
    endtask : check_field

    task automatic check_count(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s count %0d expected %0d", $time, m, got, exp);
        end
    endtask : check_count

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
    endfunction : lfsr_next

    function automatic tbid_op_type exp_op(input logic [11:0] w);
        if (w[11:9] == 3'b101) return jump_absolute;
        case (w[11:8])
            4'h4: return bit_zero;
            4'h5: return bit_one;
            4'h6, 4'h7: return bit_test;
            4'h8: return return_with_constant;
            4'h9: return call_subroutine;
            4'hc: return load_constant;
            4'hd: return or_constant;
            4'he: return and_constant;
            4'hf: return xor_constant;
            default: ;
        endcase
        case (w[11:6])
            6'h07: return add_acc_to_file;
            6'h02: return subtract_acc_from_file;
            6'h05: return and_acc_with_file;
            6'h04: return or_acc_with_file;
            6'h06: return xor_acc_with_file;
            6'h09: return invert_file;
            6'h0a: return plus_one_file;
            6'h03: return minus_one_file;
            6'h08: return copy_file;
            6'h0b: return minus_one_skip_zero;
            6'h0f: return plus_one_skip_zero;
            6'h0d: return rotate_left_carry;
            6'h0c: return rotate_right_carry;
            6'h0e: return nibble_exchange;
            6'h01: return w[5] ? zero_file : ((w == 12'h040) ? zero_acc : no_operation);
            default: ;
        endcase
        if (w[5]) return store_acc_to_file;
        case (w[4:0])
            5'h02: return prescaler_load;
            5'h03: return standby_enter;
            5'h04: return watchdog_restart;
            5'h05, 5'h06, 5'h07: return direction_latch_load;
            default: return no_operation;
        endcase
    endfunction : exp_op

    function automatic logic [2:0] exp_flags(input tbid_op_type o);
        case (o)
            add_acc_to_file, subtract_acc_from_file: return 3'h7;
            rotate_left_carry, rotate_right_carry: return 3'h4;
            and_acc_with_file, or_acc_with_file, xor_acc_with_file, invert_file,
            plus_one_file, minus_one_file, copy_file, zero_file, zero_acc, and_constant,
            or_constant, xor_constant: return 3'h1;
            default: return 3'h0;
        endcase
    endfunction : exp_flags

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        @(negedge aclk);
        while (awready !== 1'b1 || wready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge aclk);
        while (bvalid !== 1'b1) @(negedge aclk);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        @(negedge aclk);
        while (arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (rvalid !== 1'b1) @(negedge aclk);
        d = rdata;
        check_word({30'h0000_0000, rresp}, 32'h0000_0000, "read resp");
        @(posedge aclk);
        rready <= 1'b0;
    endtask : bus_read

    task automatic run_instr(input logic [11:0] w, input logic gated);
        logic [1:0] r;
        logic [31:0] rd;
        tbid_op_type eo;
        logic pc, two, isbyte, sp;
        int nb, ns, nw, nsb, perr;
        eo = exp_op(w);
        pc = (eo == jump_absolute || eo == call_subroutine || eo == return_with_constant
            || w == 12'h1e2);
        two = pc || ((eo == minus_one_skip_zero || eo == plus_one_skip_zero) && lfsr[0])
            || (eo == bit_test && (w[8] ? lfsr[1] : !lfsr[1]));
        isbyte = w[11:10] == 2'b00 && (w[11:6] != 6'h00 || w[5]) && eo != no_operation
            && eo != zero_acc;
        // Self-modifying file writes take their source from the pins
        sp = (isbyte && w[5] && eo != zero_file && eo != store_acc_to_file)
            || eo == bit_zero || eo == bit_one;
        @(posedge aclk);
        want_zero <= lfsr[0];
        want_bit <= lfsr[1];
        bus_write(4'h0, {20'h0_0000, w}, r);
        check_word({30'h0000_0000, r}, 32'h0000_0000, "instr write resp");
        if (gated) begin
            repeat (8) @(negedge aclk);
            check_field({8'h00, busy}, 9'h000, "held while stopped");
            bus_read(4'h8, rd);
            check_word(rd, 32'h0000_0043, "pending status");
            bus_write(4'h4, 32'h0000_0001, r);
        end
        @(negedge aclk);
        while (busy !== 1'b1) @(negedge aclk);
        check_field(9'(op), 9'(eo), "op");
        check_field({6'h00, flag_update}, {6'h00, exp_flags(eo)}, "flags");
        check_field({4'h0, file_addr}, {4'h0, w[4:0]}, "file");
        check_field({6'h00, bit_sel}, {6'h00, w[7:5]}, "bit");
        check_field(literal, (eo == jump_absolute) ? w[8:0] : {1'b0, w[7:0]}, "k");
        check_field({8'h00, pc_load}, {8'h00, pc}, "pc load");
        check_field({8'h00, pc_bit9_clear}, {8'h00, pc && eo != jump_absolute}, "pc9");
        if (isbyte) check_field({8'h00, dest_file}, {8'h00, w[5]}, "dest");
        check_field({8'h00, source_pins}, {8'h00, sp}, "pin source");
        nb = 0;
        ns = 0;
        nw = 0;
        nsb = 0;
        perr = 0;
        repeat (12) begin
            if (busy === 1'b1) begin
                if (phase !== 2'(nb % 4)) perr++;
                nb++;
            end
            ns += (squash === 1'b1);
            nw += (wdt_restart === 1'b1);
            nsb += (standby_pulse === 1'b1);
            @(negedge aclk);
        end
        check_count(perr, 0, "phase order");
        check_count(nb, two ? 8 : 4, "busy cycles");
        check_count(ns, two ? 4 : 0, "squash cycles");
        check_count(nw, (eo == watchdog_restart || eo == standby_enter), "wdt");
        check_count(nsb, eo == standby_enter, "standby");
        if (eo == watchdog_restart) {eto, epd} = 2'b11;
        if (eo == standby_enter) {eto, epd, eosc} = 3'b101;
        check_word({29'h0, osc_off, timeout_flag, powerdown_flag}, {29'h0, eosc, eto, epd},
            "power flags");
        bus_read(4'hc, rd);
        check_field(9'(rd[15:11]), 9'(eo), "decode op");
        lfsr = lfsr_next(lfsr);
    endtask : run_instr

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        conclude();
    end

    initial begin
        logic [1:0] r;
        logic [31:0] rd;
        logic [11:0] w, m;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        bus_read(4'h8, rd);
        check_word(rd, 32'h0000_0003, "reset status");
        bus_read(4'h4, rd);
        check_word(rd, 32'h0000_0000, "reset ctrl");
        bus_write(4'h8, 32'hffff_ffff, r);
        check_word({30'h0, r}, 32'h0000_0002, "read-only write");
        for (int rep = 0; rep < 2; rep++) begin
            for (int i = 0; i < 38; i++) begin
                w = prog[i];
                m = (w[11:9] == 3'b101) ? 12'h1ff : (w[11:10] != 2'b00) ? 12'h0ff :
                    (w[11:7] == 5'h00) ? (w[5] ? 12'h01f : 12'h000) : 12'h03f;
                w = w | (lfsr[15:4] & m);
                if (m[0] && w[4:0] == 5'h02) w[0] = 1'b1;
                run_instr(w, rep == 0 && i == 0);
            end
        end
        run_instr(12'h1e2, 1'b0);
        conclude();
    end
endmodule : twelve_bit_instruction_decoder_tb_top
